/* dv/mpp_mem_model.sv */
/* Asynchronous memory with an external address latch.
   Latch strobe level comes in already corrected for polarity. */
`timescale 1ns/1ns
module mpp_mem_model
  import mpp_pkg::*;
(
  // Clock and strobes
  input wire logic ref_clk_i,
  input wire logic rd_n_i,
  input wire logic wr_n_i,
  input wire logic ale_act_i,
  input wire logic wide_i,
  // Shared lines
  input wire logic [BUS_W-1:0] bus_out_i,
  input wire logic [BUS_W-1:0] bus_oe_i,
  output logic [BUS_W-1:0] bus_o,
  output logic [BUS_W-1:0] wr_data_o
);
  logic [BUS_W-1:0] lat;
  logic [BYTE_W-1:0] rbyte;
  logic [BUS_W-1:0] rdat;
  // Captured on the edge that ends the strobe: pins and strobe change together there
  always_ff @(posedge ref_clk_i) if (ale_act_i) lat <= bus_out_i;
  // Low address byte counts only where the port really drives it
  assign rbyte = lat[7:0] ^ (bus_out_i[15:8] & bus_oe_i[15:8]) ^ 8'h3c;
  assign rdat = wide_i ? lat ^ 16'hc35a : {rbyte, rbyte};
  // Undriven lines rest at the pull-up level
  assign bus_o = (bus_out_i & bus_oe_i) | (~bus_oe_i & (rd_n_i ? 16'hffff : rdat));
  always_ff @(posedge ref_clk_i) if (!wr_n_i) wr_data_o <= bus_out_i;
endmodule

/* dv/mpp_port_assertions.sv */
/* Pin-level assertions for mpp_port.
   Bound to mpp_port from the bench top; one clock domain. */
`timescale 1ns/1ns
module mpp_port_assertions
  import mpp_pkg::*;
(
  // Clock, reset, configuration
  input wire logic ref_clk_i,
  input wire logic rst_i,
  input wire logic wide_mode_i,
  input wire logic ale_active_low_i,
  input wire logic flag_mode_i,
  input wire logic [4:0] data_cycles_i,
  // Requests and pins
  input wire logic req_valid_i,
  input wire mpp_req_t req_i,
  input wire logic req_ready_o,
  input wire logic rsp_valid_o,
  input wire logic [BUS_W-1:0] bus_out_o,
  input wire logic [BUS_W-1:0] bus_oe_o,
  input wire logic rd_n_o,
  input wire logic wr_n_o,
  input wire logic ale_o
);
  logic [4:0] strb_cnt_ff;
  logic [4:0] nxt_strb_cnt;
  logic strb_on;
  assign strb_on = !rd_n_o || !wr_n_o;
  always_comb nxt_strb_cnt = strb_on ? strb_cnt_ff + CNT_ONE : CNT_ZERO;
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) strb_cnt_ff <= CNT_ZERO;
    else strb_cnt_ff <= nxt_strb_cnt;
  end
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (rst_i);
  sequence s_take; req_valid_i && req_ready_o && !flag_mode_i; endsequence
  sequence s_wide_rd; req_valid_i && req_ready_o && !flag_mode_i && wide_mode_i && !req_i.write; endsequence
  sequence s_wide_wr; req_valid_i && req_ready_o && !flag_mode_i && wide_mode_i && req_i.write; endsequence
  a_addr_first: assert property (s_take ##0 wide_mode_i |-> ##2 ale_o != ale_active_low_i &&
    bus_oe_o == '1 && bus_out_o == $past(req_i.addr[15:0], 2)) else $error("address phase wrong");
  a_rd_strobe: assert property (s_wide_rd |-> ##3 !rd_n_o && wr_n_o && bus_oe_o == '0)
    else $error("read strobe wrong");
  a_wr_strobe: assert property (s_wide_wr |-> ##3 !wr_n_o && rd_n_o && bus_out_o == $past(req_i.wdata, 3))
    else $error("write strobe wrong");
  a_strb_len: assert property ($fell(strb_on) |-> strb_cnt_ff ==
    (data_cycles_i < DATA_CYC_MIN ? DATA_CYC_MIN : data_cycles_i)) else $error("strobe length wrong");
  a_rsp_pulse: assert property ($rose(rd_n_o) |-> rsp_valid_o ##1 !rsp_valid_o)
    else $error("read answer wrong");
  a_ready_low: assert property (s_take |=> !req_ready_o [*4]) else $error("ready during access");
  a_ale_idle: assert property (strb_on |-> ale_o == ale_active_low_i) else $error("latch strobe level");
  a_flag_quiet: assert property (flag_mode_i [*2] |-> rd_n_o && wr_n_o && !req_ready_o &&
    ale_o == ale_active_low_i) else $error("strobe in flag mode");
  a_reset_idle: assert property (@(posedge ref_clk_i) disable iff (1'b0) rst_i |-> bus_oe_o == '0 &&
    rd_n_o && wr_n_o && !ale_o && !req_ready_o) else $error("pins not idle in reset");
endmodule

/* dv/muxed_parallel_memory_port_tb_top.sv */
/* Self-checking bench for mpp_port with a memory model.
   Inputs change on the falling edge; only reset is raised earlier, at 1 ns. */
`timescale 1ns/1ns
module muxed_parallel_memory_port_tb_top;
  import mpp_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b0, wide = 1'b1, alel = 1'b0, flag = 1'b0, vld = 1'b0;
  logic rdy, rspv, rd_n, wr_n, ale;
  logic [4:0] dcyc = 5'h02;
  mpp_req_t req = '0;
  logic [15:0] rsp, bin, bout, boe, wdat;
  int err_count = 0, compares = 0, cyc = 0, ales = 0;
  always #5 clk = ~clk;
  mpp_port dut_u (.ref_clk_i(clk), .rst_i(rst), .wide_mode_i(wide), .ale_active_low_i(alel),
    .flag_mode_i(flag), .data_cycles_i(dcyc), .req_valid_i(vld), .req_i(req), .req_ready_o(rdy),
    .rsp_valid_o(rspv), .rsp_data_o(rsp), .bus_in_i(bin), .bus_out_o(bout), .bus_oe_o(boe),
    .rd_n_o(rd_n), .wr_n_o(wr_n), .ale_o(ale));
  mpp_mem_model mem_u (.ref_clk_i(clk), .rd_n_i(rd_n), .wr_n_i(wr_n), .ale_act_i(ale ^ alel),
    .wide_i(wide), .bus_out_i(bout), .bus_oe_i(boe), .bus_o(bin), .wr_data_o(wdat));
  task report_and_stop();
    $display("compares %0d mismatches %0d", compares, err_count);
    if (err_count == 0 && compares > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 5000) begin
      err_count++;
      report_and_stop();
    end
  end
  // Counted on the falling edge, half a cycle after launch, where the strobe has settled
  always @(negedge clk) begin
    if ((ale ^ alel) === 1'b1) ales++;
  end
  task chk(string what, logic [15:0] got, logic [15:0] exp);
    compares++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task access(logic w, logic [23:0] a, logic [15:0] d);
    int n;
    n = 0;
    @(negedge clk);
    req = '{w, a, d};
    vld = 1'b1;
    ales = 0;
    while (rdy !== 1'b1 && n < 50) begin
      @(negedge clk);
      n++;
    end
    @(negedge clk);
    vld = 1'b0;
    while (rdy !== 1'b1 && n < 100) begin
      @(negedge clk);
      n++;
    end
  endtask
  task t_reset();
    chk("oe", boe, 16'h0000);
    chk("strobes", 16'({rd_n, wr_n, ale}), 16'h0006);
    chk("lines", bin, 16'hffff);
    $display("t_reset done");
  endtask
  task t_wide();
    wide = 1'b1;
    dcyc = 5'h00;
    access(1'b1, 24'h001234, 16'hbeef);
    chk("wide wdata", wdat, 16'hbeef);
    chk("wide ale", 16'(ales), 16'(ALE_CYC));
    dcyc = 5'h07;
    access(1'b0, 24'h004321, 16'h0000);
    chk("wide rdata", rsp, 16'h4321 ^ 16'hc35a);
    $display("t_wide done");
  endtask
  task t_narrow();
    wide = 1'b0;
    dcyc = 5'h03;
    access(1'b0, 24'h123456, 16'h0000);
    chk("narrow rdata", rsp, {8'h00, 8'h34 ^ 8'h56 ^ 8'h3c});
    access(1'b0, 24'h1234a0, 16'h0000);
    chk("same upper ale", 16'(ales), 16'h0000);
    chk("kept upper", rsp, {8'h00, 8'h34 ^ 8'ha0 ^ 8'h3c});
    access(1'b1, 24'h123501, 16'h00c7);
    chk("new upper ale", 16'(ales), 16'(ALE_CYC));
    chk("narrow wdata", wdat, 16'h01c7);
    $display("t_narrow done");
  endtask
  task t_flag();
    flag = 1'b1;
    @(negedge clk);
    ales = 0;
    vld = 1'b1;
    repeat (10) @(negedge clk);
    chk("flag pins", 16'({rdy, rd_n, wr_n}), 16'h0003);
    chk("flag ale", 16'(ales), 16'h0000);
    vld = 1'b0;
    flag = 1'b0;
    $display("t_flag done");
  endtask
  task t_pol();
    alel = 1'b1;
    wide = 1'b1;
    repeat (2) @(negedge clk);
    access(1'b0, 24'h000f0f, 16'h0000);
    chk("low ale", 16'(ales), 16'(ALE_CYC));
    chk("low rdata", rsp, 16'h0f0f ^ 16'hc35a);
    alel = 1'b0;
    $display("t_pol done");
  endtask
  initial begin
    // A real rising edge, so the asynchronous reset takes hold before the first clock
    #1 rst = 1'b1;
    repeat (10) @(negedge clk);
    t_reset();
    rst = 1'b0;
    t_wide();
    t_narrow();
    t_flag();
    t_pol();
    report_and_stop();
  end
endmodule
bind mpp_port mpp_port_assertions chk_u (
  .ref_clk_i(ref_clk_i),
  .rst_i(rst_i),
  .wide_mode_i(wide_mode_i),
  .ale_active_low_i(ale_active_low_i),
  .flag_mode_i(flag_mode_i),
  .data_cycles_i(data_cycles_i),
  .req_valid_i(req_valid_i),
  .req_i(req_i),
  .req_ready_o(req_ready_o),
  .rsp_valid_o(rsp_valid_o),
  .bus_out_o(bus_out_o),
  .bus_oe_o(bus_oe_o),
  .rd_n_o(rd_n_o),
  .wr_n_o(wr_n_o),
  .ale_o(ale_o)
);

/* hw/mpp_pkg.sv */
/*
  Package for the multiplexed parallel memory port: widths, timing counts,
  command and pin-group structs.
  Assumes a single 100 MHz clock domain.
*/
package mpp_pkg;
  localparam int unsigned CLK_PERIOD_NS = 10;
  localparam int unsigned ADDR_W = 24;
  localparam int unsigned BUS_W = 16;
  localparam int unsigned BYTE_W = 8;
  // Phase lengths in ns, converted to whole cycles (least times round up)
  localparam int unsigned ALE_TIME_NS = 10;
  localparam int unsigned ALE_CYC = (ALE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned HOLD_TIME_NS = 10;
  localparam int unsigned HOLD_CYC = (HOLD_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [4:0] DATA_CYC_MIN = 5'h02;
  localparam logic [4:0] DATA_CYC_RST = 5'h02;
  localparam logic [4:0] CNT_ONE = 5'h01;
  localparam logic [4:0] CNT_ZERO = 5'h00;
  localparam logic [4:0] ALE_CNT = 5'(ALE_CYC);
  localparam logic [4:0] HOLD_CNT = 5'(HOLD_CYC);
  localparam logic ALE_POL_RST = 1'b1;
  localparam logic [7:0] UPPER_LO = 8'h08;

  typedef enum logic [2:0] {
    MPP_IDLE = 3'b000,
    MPP_ADDR = 3'b001,
    MPP_TURN = 3'b010,
    MPP_DATA = 3'b011,
    MPP_HOLD = 3'b100
  } mpp_state_t;

  typedef struct packed {
    logic write;
    logic [ADDR_W-1:0] addr;
    logic [BUS_W-1:0] wdata;
  } mpp_req_t;

  typedef struct packed {
    logic [BUS_W-1:0] out;
    logic [BUS_W-1:0] oe;
    logic rd_n;
    logic wr_n;
    logic ale;
  } mpp_pins_t;
endpackage

/* hw/mpp_port.sv */
/*
  Multiplexed parallel memory port: address and data share sixteen lines,
  qualified by an address latch strobe and active-low read/write strobes.
  Assumes an external address latch and asynchronous memory; requests are
  synchronous to ref_clk_i and held until accepted.
*/
`timescale 1ns/1ns
// Overview of operation
// RULE1: Addresses and data both go out on the sixteen shared lines, the latch strobe marking the address phase.
// RULE2: The port runs in an 8-bit or a 16-bit data width, chosen by the width input.
// RULE3: In 8-bit mode the latch strobe is pulsed whenever the upper sixteen address bits differ from the last ones.
// RULE4: In 8-bit mode the outside latch captures the upper address bits on the strobe and holds them.
// RULE5: The read strobe is low for every read of 8 or 16 bits and high otherwise.
// RULE6: The write strobe is low for every write of 8 or 16 bits and high otherwise.
// RULE7: The latch strobe is asserted each time a new address is driven onto the shared lines.
// RULE8: The latch strobe is active high after reset and can be set active low.
// RULE9: When the lines serve as flags, read, write and latch strobes all stay inactive.
// RULE10: Each access drives the address with the latch strobe first, then the data phase with its strobe. No 8-bit address phase while upper bits repeat.
// RULE11: During and after reset the bus floats, read and write stay high and the latch strobe is inactive.
module mpp_port
  import mpp_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk_i,
  input wire logic rst_i,
  // Configuration
  input wire logic wide_mode_i,
  input wire logic ale_active_low_i,
  input wire logic flag_mode_i,
  input wire logic [4:0] data_cycles_i,
  // Request side
  input wire logic req_valid_i,
  input wire mpp_req_t req_i,
  output logic req_ready_o,
  output logic rsp_valid_o,
  output logic [BUS_W-1:0] rsp_data_o,
  // Shared bus pins
  input wire logic [BUS_W-1:0] bus_in_i,
  output logic [BUS_W-1:0] bus_out_o,
  output logic [BUS_W-1:0] bus_oe_o,
  output logic rd_n_o,
  output logic wr_n_o,
  output logic ale_o
);
  mpp_state_t state_ff, nxt_state;
  mpp_req_t cur_ff, nxt_cur;
  mpp_pins_t pins_ff, nxt_pins;
  logic [4:0] cnt_ff, nxt_cnt;
  logic ale_pol_ff, nxt_ale_pol;
  logic wide_ff, nxt_wide;
  logic ready_ff, nxt_ready;
  logic rsp_valid_ff, nxt_rsp_valid;
  logic [BUS_W-1:0] rsp_data_ff, nxt_rsp_data;
  logic upper_change;
  logic upper_load;

  // Latch strobe level for a given logical assertion
  function automatic logic ale_level(input logic act, input logic pol);
    ale_level = pol ? act : !act;
  endfunction

  // Data-phase length, never below the minimum
  function automatic logic [4:0] data_len(input logic [4:0] req);
    data_len = (req < DATA_CYC_MIN) ? DATA_CYC_MIN : req;
  endfunction

  mpp_upper_track u_track (
    .ref_clk_i(ref_clk_i),
    .rst_i(rst_i),
    .upper_i(cur_ff.addr[ADDR_W-1:BYTE_W]),
    .load_i(upper_load),
    .change_o(upper_change)
  );

  always_comb begin
    nxt_state = state_ff;
    nxt_cur = cur_ff;
    nxt_pins = pins_ff;
    nxt_cnt = cnt_ff;
    nxt_ale_pol = !ale_active_low_i; // [RULE8]
    nxt_wide = wide_ff;
    nxt_ready = 1'b0;
    nxt_rsp_valid = 1'b0;
    nxt_rsp_data = rsp_data_ff;
    upper_load = 1'b0;
    nxt_pins.rd_n = 1'b1; // [RULE5] [RULE6]
    nxt_pins.wr_n = 1'b1;
    nxt_pins.ale = ale_level(1'b0, ale_pol_ff);
    nxt_pins.oe = '0;
    case (state_ff)
      MPP_IDLE: begin
        nxt_ready = !flag_mode_i && !req_valid_i; // [RULE9]
        if (ready_ff && req_valid_i && !flag_mode_i) begin
          nxt_ready = 1'b0;
          nxt_cur = req_i;
          nxt_wide = wide_mode_i; // [RULE2]
          nxt_state = MPP_ADDR;
          nxt_cnt = CNT_ZERO;
        end else if (req_valid_i) begin
          nxt_ready = !flag_mode_i;
        end
      end
      MPP_ADDR: begin
        // Wide mode: 16 address bits every access; narrow: upper bits only on change
        if (wide_ff || upper_change) begin // [RULE3] [RULE7]
          nxt_pins.out = wide_ff ? cur_ff.addr[BUS_W-1:0] : cur_ff.addr[ADDR_W-1:BYTE_W]; // [RULE1]
          nxt_pins.oe = '1;
          nxt_pins.ale = ale_level(1'b1, ale_pol_ff); // [RULE10]
          upper_load = !wide_ff;
          nxt_state = MPP_TURN;
          nxt_cnt = ALE_CNT;
        end else begin
          nxt_state = MPP_TURN;
          nxt_cnt = CNT_ZERO;
        end
      end
      MPP_TURN: begin
        if (cnt_ff > CNT_ONE) begin
          nxt_pins.oe = pins_ff.oe;
          nxt_pins.ale = pins_ff.ale;
          nxt_cnt = cnt_ff - CNT_ONE;
        end else begin
          // Narrow mode: low address byte on the upper lines, data on the lower ones
          nxt_pins.out = wide_ff ? cur_ff.wdata : {cur_ff.addr[BYTE_W-1:0], cur_ff.wdata[BYTE_W-1:0]}; // [RULE1]
          if (wide_ff) begin
            nxt_pins.oe = cur_ff.write ? 16'hffff : 16'h0000;
          end else begin
            nxt_pins.oe = cur_ff.write ? 16'hffff : 16'hff00;
          end
          nxt_pins.rd_n = cur_ff.write; // [RULE5]
          nxt_pins.wr_n = !cur_ff.write; // [RULE6]
          nxt_cnt = data_len(data_cycles_i);
          nxt_state = MPP_DATA;
        end
      end
      MPP_DATA: begin
        nxt_pins.oe = pins_ff.oe;
        nxt_pins.rd_n = pins_ff.rd_n;
        nxt_pins.wr_n = pins_ff.wr_n;
        nxt_cnt = cnt_ff - CNT_ONE;
        if (cnt_ff <= CNT_ONE) begin
          nxt_pins.rd_n = 1'b1;
          nxt_pins.wr_n = 1'b1;
          nxt_rsp_valid = !cur_ff.write;
          nxt_rsp_data = wide_ff ? bus_in_i : {8'h00, bus_in_i[BYTE_W-1:0]};
          nxt_cnt = HOLD_CNT;
          nxt_state = MPP_HOLD;
        end
      end
      MPP_HOLD: begin
        // Keep write data one cycle past the strobe's rise for memory hold time
        nxt_pins.oe = pins_ff.oe;
        nxt_cnt = cnt_ff - CNT_ONE;
        if (cnt_ff <= CNT_ONE) begin
          nxt_pins.oe = '0;
          nxt_state = MPP_IDLE;
          nxt_ready = !flag_mode_i;
        end
      end
      default: begin
        nxt_state = MPP_IDLE;
      end
    endcase
    if (flag_mode_i) begin
      nxt_pins.rd_n = 1'b1; // [RULE9]
      nxt_pins.wr_n = 1'b1;
      nxt_pins.ale = ale_level(1'b0, ale_pol_ff);
      nxt_pins.oe = '0;
    end
  end

  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      state_ff <= MPP_IDLE;
      cur_ff <= '0;
      pins_ff.out <= '0;
      pins_ff.oe <= '0; // [RULE11]
      pins_ff.rd_n <= 1'b1;
      pins_ff.wr_n <= 1'b1;
      pins_ff.ale <= !ALE_POL_RST;
      cnt_ff <= CNT_ZERO;
      ale_pol_ff <= ALE_POL_RST;
      wide_ff <= 1'b0;
      ready_ff <= 1'b0;
      rsp_valid_ff <= 1'b0;
      rsp_data_ff <= '0;
    end else begin
      state_ff <= nxt_state;
      cur_ff <= nxt_cur;
      pins_ff <= nxt_pins;
      cnt_ff <= nxt_cnt;
      ale_pol_ff <= nxt_ale_pol;
      wide_ff <= nxt_wide;
      ready_ff <= nxt_ready;
      rsp_valid_ff <= nxt_rsp_valid;
      rsp_data_ff <= nxt_rsp_data;
    end
  end

  assign req_ready_o = ready_ff;
  assign rsp_valid_o = rsp_valid_ff;
  assign rsp_data_o = rsp_data_ff;
  assign bus_out_o = pins_ff.out;
  assign bus_oe_o = pins_ff.oe;
  assign rd_n_o = pins_ff.rd_n;
  assign wr_n_o = pins_ff.wr_n;
  assign ale_o = pins_ff.ale;
endmodule

/* hw/mpp_upper_track.sv */
/*
  Tracks the upper address bits last sent out in narrow mode and flags a
  change so the port issues a fresh latch strobe.
  Assumes the caller loads the tracker whenever a narrow-mode address phase happens.
*/
`timescale 1ns/1ns
module mpp_upper_track
  import mpp_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk_i,
  input wire logic rst_i,
  // Compare and load
  input wire logic [15:0] upper_i,
  input wire logic load_i,
  output logic change_o
);
  logic [15:0] last_ff;
  logic [15:0] nxt_last;
  logic valid_ff;
  logic nxt_valid;

  always_comb begin
    nxt_last = last_ff;
    nxt_valid = valid_ff;
    if (load_i) begin
      nxt_last = upper_i;
      nxt_valid = 1'b1;
    end
  end

  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      last_ff <= 16'h0000;
      valid_ff <= 1'b0;
    end else begin
      last_ff <= nxt_last;
      valid_ff <= nxt_valid;
    end
  end

  // First access after reset always counts as a change
  assign change_o = !valid_ff || (upper_i != last_ff);
endmodule
